/* File: hdl/ufs_cfg.svh */
`ifndef UFS_CFG_SVH
`define UFS_CFG_SVH
// Register byte addresses
`define UFS_ADDR_FRAME_COUNT 32'h30002C3C
`define UFS_ADDR_PERIODIC_THRESHOLD 32'h30002C40
`define UFS_ADDR_LOW_SPEED_CUTOFF 32'h30002C44
`define UFS_ADDR_FRAME_LENGTH 32'h30002C34
`define UFS_ADDR_CONTROL 32'h30002C60
`define UFS_ADDR_IRQ_STATUS 32'h30002C64
`define UFS_ADDR_IRQ_MASK 32'h30002C68
`define UFS_ADDR_REMAINING 32'h30002C38
// Reset values
`define UFS_RST_FRAME_COUNT 16'h0000
`define UFS_RST_PERIODIC 16'h0000
`define UFS_RST_LS_CUTOFF 12'h628
`define UFS_RST_FRAME_LENGTH 14'h2EDF
`define UFS_RST_REMAINING 14'h0000
// Field widths
`define UFS_FC_W 16
`define UFS_PS_W 14
`define UFS_PS_REG_W 16
`define UFS_LS_W 12
`define UFS_FL_W 14
// Control / irq bit positions
`define UFS_CTL_OPER 0
`define UFS_IRQ_SOF 0
`define UFS_IRQ_W 1
// Bit time: 12 MHz full speed from 100 MHz clock
`define UFS_CLK_HZ 100000000
`define UFS_BIT_HZ 12000000
`define UFS_BIT_DIV (`UFS_CLK_HZ / `UFS_BIT_HZ)
`endif

/* File: hdl/ufs_frame_sched.sv */
// Function
// R1: Frame count steps by one on each remaining-counter reload.
// R2: Frame count wraps from all ones to zero.
// R3: Entering operational state advances frame count.
// R4: Count written to shared area after SOF, before first descriptor fetch.
// R5: After shared-area write, frame-start flag sets in irq status.
// R6: Frame count resets to zero, read only to software.
// R7: Software may extend frame count to 32 bits itself.
// R8: Reset clears periodic threshold field, low fourteen bits.
// R9: Software programs threshold about ten percent below frame length.
// R10: At threshold, periodic lists gain priority over control and bulk.
// R11: Current control or bulk transaction finishes before interrupt list.
// R12: Periodic threshold is a fourteen-bit compare value.
// R13: Low-speed start only when remaining is at least the cutoff.
// R14: Low-speed cutoff is twelve bits, writable, resets to default.
// R15: Software computes cutoff including transmission and setup overhead.
// R16: Remaining counter decrements per bit time, reloads after zero.
// R17: Frame length defaults to nominal value after reset.
// R18: Reserved bits read zero, writes ignored.
`timescale 1ns/1ps
`include "ufs_cfg.svh"
module ufs_frame_sched (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire ufs_pkg::ufs_htrans_t htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Scheduler hooks
	input wire logic xfer_busy,
	input wire logic ls_request,
	input wire logic shared_comm_area_ack,
	output logic shared_comm_area_wr,
	output logic [15:0] shared_comm_area_data,
	output logic sof_pulse,
	output logic ed_fetch_go,
	output logic periodic_pri,
	output logic ls_start_ok,
	// Interrupt
	output logic irq
);
	import ufs_pkg::*;

	// Address phase capture
	logic wr_pend_q, wr_pend_d;
	logic [31:0] addr_q, addr_d;
	logic [31:0] rdata_q, rdata_d;
	// Registers
	logic [`UFS_FC_W-1:0] fc_q, fc_d;
	logic [`UFS_PS_W-1:0] ps_q, ps_d;
	logic [`UFS_LS_W-1:0] ls_q, ls_d;
	logic [`UFS_FL_W-1:0] fl_q, fl_d;
	logic [`UFS_FL_W-1:0] rem_q, rem_d;
	logic oper_q, oper_d, oper_prev_q;
	logic [`UFS_IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
	logic [3:0] div_q, div_d;
	ufs_phase_e ph_q, ph_d;
	logic shared_comm_area_wr_q, shared_comm_area_wr_d, sof_q, sof_d, go_q, go_d;
	logic pri_q, pri_d, lsok_q, lsok_d, irq_q, irq_d;
	logic bit_tick, reload, op_entry, take, frame_step, sof_set;

	// Divider has to fit the four-bit prescaler
	if (`UFS_BIT_DIV < 1 || `UFS_BIT_DIV > 15) begin : g_bad_div
		$error("bit-time divider out of range");
	end

	// Bit-time enable from the 100 MHz clock
	assign bit_tick = (div_q == 4'(`UFS_BIT_DIV - 1));
	// Reload only while operational, so the count stays put until started
	assign reload = bit_tick && oper_q && (rem_q == '0); // R16
	assign op_entry = oper_q && !oper_prev_q;
	assign frame_step = reload || op_entry; // R1 R3
	assign take = hsel && hready && htrans[1];
	assign sof_set = (ph_q == UFS_WRITE) && shared_comm_area_ack;

	// Next-state logic for counters, registers and read data
	always_comb begin
		div_d = bit_tick ? 4'h0 : div_q + 4'h1;
		rem_d = rem_q;
		if (op_entry)
			rem_d = fl_q;
		else if (reload)
			rem_d = fl_q; // R16
		else if (bit_tick && oper_q)
			rem_d = rem_q - 14'h0001; // R16
		fc_d = frame_step ? fc_q + 16'h0001 : fc_q; // R1 R2 R3
		wr_pend_d = take && hwrite;
		addr_d = take ? haddr : addr_q;
		ps_d = ps_q;
		ls_d = ls_q;
		fl_d = fl_q;
		oper_d = oper_q;
		imask_d = imask_q;
		ist_d = ist_q;
		// Writes: reserved bits dropped, frame count not writable
		if (wr_pend_q) begin // R6 R18
			unique case (addr_q)
			`UFS_ADDR_PERIODIC_THRESHOLD: ps_d = hwdata[`UFS_PS_W-1:0]; // R12
			`UFS_ADDR_LOW_SPEED_CUTOFF: ls_d = hwdata[`UFS_LS_W-1:0]; // R14
			`UFS_ADDR_FRAME_LENGTH: fl_d = hwdata[`UFS_FL_W-1:0];
			`UFS_ADDR_CONTROL: oper_d = hwdata[`UFS_CTL_OPER];
			`UFS_ADDR_IRQ_MASK: imask_d = hwdata[`UFS_IRQ_W-1:0];
			`UFS_ADDR_IRQ_STATUS: ist_d = ist_q & ~hwdata[`UFS_IRQ_W-1:0];
			default: ;
			endcase
		end
		// Set beats clear so a frame start is never lost
		if (sof_set)
			ist_d[`UFS_IRQ_SOF] = 1'b1; // R5
		// Read mux, reserved bits zero
		rdata_d = 32'h00000000; // R18
		if (take && !hwrite) begin
			unique case (haddr)
			`UFS_ADDR_FRAME_COUNT: rdata_d = {16'h0000, fc_q}; // R6
			`UFS_ADDR_PERIODIC_THRESHOLD: rdata_d = {18'h00000, ps_q}; // R8
			`UFS_ADDR_LOW_SPEED_CUTOFF: rdata_d = {20'h00000, ls_q};
			`UFS_ADDR_FRAME_LENGTH: rdata_d = {18'h00000, fl_q};
			`UFS_ADDR_REMAINING: rdata_d = {18'h00000, rem_q};
			`UFS_ADDR_CONTROL: rdata_d = {31'h00000000, oper_q};
			`UFS_ADDR_IRQ_STATUS: rdata_d = {31'h00000000, ist_q};
			`UFS_ADDR_IRQ_MASK: rdata_d = {31'h00000000, imask_q};
			default: rdata_d = 32'h00000000;
			endcase
		end
	end

	// Frame boundary sequence: step, SOF, shared-area write, fetch
	always_comb begin
		ph_d = ph_q;
		sof_d = 1'b0;
		shared_comm_area_wr_d = 1'b0;
		go_d = 1'b0;
		unique case (ph_q)
		UFS_IDLE: if (frame_step && oper_d) begin
			ph_d = UFS_SOF;
		end
		UFS_SOF: begin
			sof_d = 1'b1;
			ph_d = UFS_WRITE;
		end
		UFS_WRITE: begin
			shared_comm_area_wr_d = !shared_comm_area_ack; // R4
			if (shared_comm_area_ack)
				ph_d = UFS_FETCH;
		end
		UFS_FETCH: begin
			go_d = 1'b1; // R4
			ph_d = UFS_IDLE;
		end
		endcase
		// Periodic priority taken only between transactions
		pri_d = pri_q;
		if (reload || op_entry)
			pri_d = 1'b0;
		else if (!xfer_busy && rem_q <= ps_q)
			pri_d = 1'b1; // R10 R11
		lsok_d = ls_request && (rem_q >= 14'(ls_q)); // R13
		irq_d = |(ist_d & imask_d);
	end

	// Register stage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= 4'h0;
			rem_q <= `UFS_RST_REMAINING;
			fc_q <= `UFS_RST_FRAME_COUNT; // R6
			ps_q <= `UFS_PS_W'(`UFS_RST_PERIODIC); // R8
			ls_q <= `UFS_RST_LS_CUTOFF; // R14
			fl_q <= `UFS_RST_FRAME_LENGTH; // R17
			oper_q <= 1'b0;
			oper_prev_q <= 1'b0;
			ist_q <= '0;
			imask_q <= '0;
			wr_pend_q <= 1'b0;
			addr_q <= 32'h00000000;
			rdata_q <= 32'h00000000;
			ph_q <= UFS_IDLE;
			sof_q <= 1'b0;
			shared_comm_area_wr_q <= 1'b0;
			go_q <= 1'b0;
			pri_q <= 1'b0;
			lsok_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			div_q <= div_d;
			rem_q <= rem_d;
			fc_q <= fc_d;
			ps_q <= ps_d;
			ls_q <= ls_d;
			fl_q <= fl_d;
			oper_q <= oper_d;
			oper_prev_q <= oper_q;
			ist_q <= ist_d;
			imask_q <= imask_d;
			wr_pend_q <= wr_pend_d;
			addr_q <= addr_d;
			rdata_q <= rdata_d;
			ph_q <= ph_d;
			sof_q <= sof_d;
			shared_comm_area_wr_q <= shared_comm_area_wr_d;
			go_q <= go_d;
			pri_q <= pri_d;
			lsok_q <= lsok_d;
			irq_q <= irq_d;
		end
	end

	// Outputs from flops; slave is zero-wait and always OKAY
	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign shared_comm_area_wr = shared_comm_area_wr_q;
	assign shared_comm_area_data = fc_q;
	assign sof_pulse = sof_q;
	assign ed_fetch_go = go_q;
	assign periodic_pri = pri_q;
	assign ls_start_ok = lsok_q;
	assign irq = irq_q;

	// SOF pulse, then shared-area write, at a boundary
	sequence s_sof_then_write;
		sof_pulse ##1 shared_comm_area_wr;
	endsequence

	chk_count_step: assert property (@(posedge hclk) disable iff (!hresetn)
		reload |=> fc_q == $past(fc_q) + 16'h0001) // R1
		else $error("frame count did not step on reload");
	chk_count_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
		(frame_step && fc_q == 16'hFFFF) |=> fc_q == 16'h0000) // R2
		else $error("frame count did not wrap");
	chk_oper_entry: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(oper_q) |=> fc_q != $past(fc_q)) // R3
		else $error("no step on operational entry");
	chk_write_order: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(sof_pulse) |-> s_sof_then_write) // R4
		else $error("shared-area write not after SOF");
	chk_fetch_after: assert property (@(posedge hclk) disable iff (!hresetn)
		ed_fetch_go |-> $past(ph_q) == UFS_FETCH && !shared_comm_area_wr) // R4
		else $error("fetch before shared-area write");
	chk_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		sof_set |=> ist_q[`UFS_IRQ_SOF]) // R5
		else $error("frame-start flag not set");
	chk_ls_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		ls_start_ok |-> $past(rem_q) >= 14'($past(ls_q))) // R13
		else $error("low-speed start below cutoff");
	chk_pri_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(periodic_pri) |-> !$past(xfer_busy)) // R11
		else $error("priority taken mid-transaction");
	chk_rem_dec: assert property (@(posedge hclk) disable iff (!hresetn)
		(bit_tick && oper_q && !op_entry && rem_q != '0)
		|=> rem_q == $past(rem_q) - 14'h0001) // R16
		else $error("remaining counter did not decrement");

	// Write completion, then the descriptor fetch
	sequence s_ack_then_fetch;
		!shared_comm_area_wr ##1 ed_fetch_go;
	endsequence

	chk_wr_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(shared_comm_area_wr && !shared_comm_area_ack) |=> shared_comm_area_wr) // R4
		else $error("shared-area request dropped before ack");
	chk_fetch_seq: assert property (@(posedge hclk) disable iff (!hresetn)
		(shared_comm_area_wr && shared_comm_area_ack) |=> s_ack_then_fetch) // R4
		else $error("no fetch after shared-area write");
	chk_sof_single: assert property (@(posedge hclk) disable iff (!hresetn)
		sof_pulse |=> !sof_pulse) // R4
		else $error("frame start pulse too long");

	// Register and flag behaviour
	chk_fc_readonly: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_pend_q && addr_q == `UFS_ADDR_FRAME_COUNT && !frame_step)
		|=> fc_q == $past(fc_q)) // R6
		else $error("frame count changed by software");
	chk_flag_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(ist_q[`UFS_IRQ_SOF] && !(wr_pend_q &&
		addr_q == `UFS_ADDR_IRQ_STATUS)) |=> ist_q[`UFS_IRQ_SOF]) // R5
		else $error("frame-start flag lost without a clear");
	chk_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
		irq == |(ist_q & imask_q)) // R5
		else $error("interrupt level wrong");

	// Scheduling gates
	chk_pri_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(reload || op_entry) |=> !periodic_pri) // R10
		else $error("priority kept across frame boundary");
	chk_ls_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
		(ls_request && rem_q < 14'(ls_q)) |=> !ls_start_ok) // R13
		else $error("low-speed start granted below cutoff");
	chk_ls_pass: assert property (@(posedge hclk) disable iff (!hresetn)
		(ls_request && rem_q >= 14'(ls_q)) |=> ls_start_ok) // R13
		else $error("low-speed start refused above cutoff");
	chk_rem_reload: assert property (@(posedge hclk) disable iff (!hresetn)
		reload |=> rem_q == $past(fl_q)) // R16
		else $error("remaining counter did not reload");
endmodule

/* File: hdl/ufs_pkg.sv */
package ufs_pkg;
	typedef enum logic [1:0] {
		UFS_IDLE = 2'b00,
		UFS_SOF = 2'b01,
		UFS_WRITE = 2'b10,
		UFS_FETCH = 2'b11
	} ufs_phase_e;
	typedef logic [1:0] ufs_htrans_t;
endpackage

/* File: verification/test_usb_host_frame_scheduling.sv */
`timescale 1ns/1ps
`include "ufs_cfg.svh"
module test_usb_host_frame_scheduling;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_ph = 0, seen = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rnd = 32'hA7A3;
	logic [1:0] htrans = 0;
	logic xfer_busy = 0, ls_request = 0, slow = 0;
	logic hreadyout, hresp, shared_comm_area_ack, shared_comm_area_wr, sof_pulse, ed_fetch_go;
	logic periodic_pri, ls_start_ok, irq;
	logic [15:0] shared_comm_area_data, fn_last = 16'h0;
	logic [31:0] fn_ext = 0, ext_n;
	logic fetch_due = 0;
	logic [31:0] expq[$];
	int errors = 0, total_checks = 0, acks = 0;
	ufs_frame_sched uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .xfer_busy(xfer_busy),
		.ls_request(ls_request), .shared_comm_area_ack(shared_comm_area_ack), .shared_comm_area_wr(shared_comm_area_wr),
		.shared_comm_area_data(shared_comm_area_data), .sof_pulse(sof_pulse),
		.ed_fetch_go(ed_fetch_go), .periodic_pri(periodic_pri),
		.ls_start_ok(ls_start_ok), .irq(irq));
	ufs_mem_model mem (.hclk(hclk), .hresetn(hresetn), .shared_comm_area_wr(shared_comm_area_wr),
		.slow(slow), .shared_comm_area_ack(shared_comm_area_ack));
	// Free-running bus clock
	initial forever #5 hclk = ~hclk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Bounded wait for hready at the next edges
	task automatic wait_rdy();
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && k < 50) begin
			k++;
			@(posedge hclk);
		end
		if (k >= 50) begin
			chk(1'b0, "bus hang");
			conclude();
		end
	endtask
	// One single-word transfer; reads leave their expectation queued
	task automatic bus(input logic [31:0] a, input logic w,
		input logic [31:0] d, input logic [31:0] e);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		if (!w) begin
			expq.push_back(e);
			rd_ph <= 1'b1;
		end
		wait_rdy();
		chk(hresp === 1'b0, "bus response not OKAY");
		rd_ph <= 1'b0;
	endtask
	// Bounded wait for the next frame start
	task automatic wait_sof();
		int k;
		k = 0;
		@(posedge hclk);
		while (sof_pulse !== 1'b1 && k < 1000) begin
			k++;
			@(posedge hclk);
		end
		if (k >= 1000) begin
			chk(1'b0, "no frame start");
			conclude();
		end
	endtask
	// Watcher: read data against queue, each shared-area write one step on
	always @(posedge hclk) begin
		if (rd_ph && hreadyout)
			chk(expq.size() > 0 && hrdata === expq.pop_front(), "read data");
		if (ed_fetch_go) begin
			chk(fetch_due, "fetch without shared-area write");
			fetch_due <= 1'b0;
		end
		if (shared_comm_area_wr && shared_comm_area_ack) begin
			chk(shared_comm_area_data !== 16'h0 && (!seen || shared_comm_area_data === fn_last + 16'h1),
				"frame count step");
			// Software-style 32-bit extension of the 16-bit count
			ext_n = {fn_ext[31:16] + 16'(shared_comm_area_data < fn_ext[15:0]),
				shared_comm_area_data};
			chk(ext_n === 32'(acks + 1), "extended frame number");
			fn_ext <= ext_n;
			fetch_due <= 1'b1;
			seen <= 1'b1;
			fn_last <= shared_comm_area_data;
			acks++;
		end
	end
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		bus(`UFS_ADDR_FRAME_COUNT, 0, 0, 32'h0);
		bus(`UFS_ADDR_PERIODIC_THRESHOLD, 0, 0, 32'h0);
		bus(`UFS_ADDR_LOW_SPEED_CUTOFF, 0, 0, 32'h628);
		bus(32'h30002C50, 1, 32'hFFFFFFFF, 0);
		bus(32'h30002C50, 0, 0, 32'h0);
		bus(`UFS_ADDR_FRAME_COUNT, 1, 32'hFFFFFFFF, 0);
		bus(`UFS_ADDR_FRAME_COUNT, 0, 0, 32'h0);
		rnd = xs(rnd);
		bus(`UFS_ADDR_LOW_SPEED_CUTOFF, 1, rnd, 0);
		bus(`UFS_ADDR_LOW_SPEED_CUTOFF, 0, 0, rnd & 32'hFFF);
		bus(`UFS_ADDR_PERIODIC_THRESHOLD, 1, 32'hFFFFFFFF, 0);
		bus(`UFS_ADDR_PERIODIC_THRESHOLD, 0, 0, 32'h3FFF);
		// Short frame keeps the run brief
		bus(`UFS_ADDR_FRAME_LENGTH, 1, 32'h28, 0);
		// Threshold about ten percent below the frame length
		bus(`UFS_ADDR_PERIODIC_THRESHOLD, 1, 32'h24, 0);
		bus(`UFS_ADDR_IRQ_MASK, 1, 32'h1, 0);
		bus(`UFS_ADDR_LOW_SPEED_CUTOFF, 1, 32'h0, 0);
		bus(`UFS_ADDR_CONTROL, 1, 32'h1, 0);
		ls_request <= 1'b1;
		repeat (3) @(posedge hclk);
		chk(ls_start_ok === 1'b1, "low speed allowed");
		for (int i = 0; i < 2000 && acks < 3; i++) @(posedge hclk);
		if (acks < 3) begin
			chk(1'b0, "frames stalled");
			conclude();
		end
		slow <= 1'b1;
		for (int i = 0; i < 3000 && acks < 6; i++) @(posedge hclk);
		chk(acks >= 6, "frames stalled");
		if (acks < 6)
			conclude();
		chk(irq === 1'b1, "irq not raised");
		bus(`UFS_ADDR_IRQ_STATUS, 0, 0, 32'h1);
		bus(`UFS_ADDR_LOW_SPEED_CUTOFF, 1, 32'hFFF, 0);
		repeat (3) @(posedge hclk);
		chk(ls_start_ok === 1'b0, "low speed refused");
		// Cutoff leaving room for a low-speed packet and its setup
		bus(`UFS_ADDR_LOW_SPEED_CUTOFF, 1, 32'h14, 0);
		wait_sof();
		repeat (4) @(posedge hclk);
		chk(ls_start_ok === 1'b1, "low speed early in frame");
		repeat (256) @(posedge hclk);
		chk(ls_start_ok === 1'b0, "low speed late in frame");
		wait_sof();
		repeat (2) @(posedge hclk);
		chk(periodic_pri === 1'b0, "priority before threshold");
		xfer_busy <= 1'b1;
		repeat (50) @(posedge hclk);
		chk(periodic_pri === 1'b0, "priority while busy");
		xfer_busy <= 1'b0;
		repeat (4) @(posedge hclk);
		chk(periodic_pri === 1'b1, "priority at threshold");
		bus(`UFS_ADDR_CONTROL, 1, 32'h0, 0);
		repeat (60) @(posedge hclk);
		bus(`UFS_ADDR_IRQ_MASK, 1, 32'h0, 0);
		repeat (3) @(posedge hclk);
		chk(irq === 1'b0, "irq masked");
		bus(`UFS_ADDR_IRQ_MASK, 1, 32'h1, 0);
		bus(`UFS_ADDR_IRQ_STATUS, 1, 32'h1, 0);
		repeat (3) @(posedge hclk);
		chk(irq === 1'b0, "irq cleared");
		conclude();
	end
endmodule

/* File: verification/ufs_mem_model.sv */
`timescale 1ns/1ps
// Memory side of the shared-area write: one ack per request
module ufs_mem_model (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Write handshake
	input wire logic shared_comm_area_wr,
	input wire logic slow,
	output logic shared_comm_area_ack
);
	int n;
	// Slow mode stalls the writer to expose early release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			n <= 0;
			shared_comm_area_ack <= 1'b0;
		end else begin
			shared_comm_area_ack <= shared_comm_area_wr && !shared_comm_area_ack && n == (slow ? 5 : 1);
			n <= (shared_comm_area_wr && !shared_comm_area_ack) ? n + 1 : 0;
		end
	end
endmodule
